// ---- src/csist_dev.sv ----
// Slave transmitter serial unit: two channels shifting out on a master clock
// Notes on behaviour
// R1 - Data shifts only on the master-supplied clock
// R2 - Per-channel interrupt: transfer end or buffer empty
// R3 - Overrun is the only detected error
// R4 - Serial clock at most operation clock / 6
// R5 - Data phase bit picks first-bit timing
// R6 - Clock phase bit inverts the serial clock
// R7 - Start register bits 0,1 start channels
// R8 - Output enable set for the target channel
// R9 - Stop bit clears running status, halts channel
// R10 - Software waits for idle before stopping
// R11 - Output enable cleared stops data drive
// R12 - Stopped, disabled channel allows forced pin levels
// R13 - Clock supply removal resets the whole unit; the code leaves the clock synchroniser and edge history flops uncleared
// R14 - After clock removal, software fully reinitialises
// R15 - Write while buffer full overwrites pending data
// R16 - Interrupt select may change before last bit
// R17 - Select 1 buffer empty, 0 transfer end
// R18 - Frames of 7 or 8 bits, MSB/LSB first
// R19 - Low byte write fills buffer, sets full flag
`timescale 1ns/1ps
`default_nettype none
module csist_dev (
  input  wire logic                          REF_CLK,
  input  wire logic                          RST_B,
  input  wire logic                          PER_CLK_EN,
  input  wire logic                          SS_WR,
  input  wire logic [csist_pkg::SS_W-1:0]    SS_DATA,
  input  wire logic                          ST_WR,
  input  wire logic [csist_pkg::SS_W-1:0]    ST_DATA,
  input  wire logic [csist_pkg::NCH-1:0]     CH_SOE,
  input  wire logic [csist_pkg::NCH-1:0]     CKP,
  input  wire logic [csist_pkg::NCH-1:0]     DAP,
  input  wire logic [csist_pkg::NCH-1:0]     IRQ_SEL,
  input  wire logic [csist_pkg::NCH-1:0]     LEN8,
  input  wire logic [csist_pkg::NCH-1:0]     MSB_FIRST,
  input  wire logic [csist_pkg::NCH-1:0]     DATA_WR,
  input  wire logic [csist_pkg::DW-1:0]      DATA_IN,
  input  wire logic [csist_pkg::NCH-1:0]     OVF_CLR,
  input  wire logic [csist_pkg::NCH-1:0]     LVL_WR,
  input  wire logic [csist_pkg::NCH-1:0]     SO_LVL,
  input  wire logic [csist_pkg::NCH-1:0]     CKO_LVL,
  output logic      [csist_pkg::NCH-1:0]     RUNNING,
  output logic      [csist_pkg::NCH-1:0]     BUSY,
  output logic      [csist_pkg::NCH-1:0]     BUF_FULL,
  output logic      [csist_pkg::NCH-1:0]     OVF,
  output logic      [csist_pkg::NCH-1:0]     IRQ,
  output logic      [csist_pkg::NCH-1:0]     CKO,
  csist_if.dev                               LINK
);

  // Bit reversal for MSB-first frames
  function automatic logic [csist_pkg::DW-1:0] csist_rev(input logic [csist_pkg::DW-1:0] d);
    logic [csist_pkg::DW-1:0] r;
    r = '0;
    for (int i = 0; i < csist_pkg::DW; i++) begin
      r[i] = d[csist_pkg::DW-1-i];
    end
    return r;
  endfunction : csist_rev

  // Start and stop decode, upper bits ignored
  wire [csist_pkg::NCH-1:0] start_ch = {csist_pkg::NCH{SS_WR}} & SS_DATA[csist_pkg::NCH-1:0]; // [R7]
  wire [csist_pkg::NCH-1:0] stop_ch  = {csist_pkg::NCH{ST_WR}} & ST_DATA[csist_pkg::NCH-1:0]; // [R9]

  for (genvar c = 0; c < csist_pkg::NCH; c++) begin : g_ch
    logic                     sck_s1_r;
    logic                     sck_s2_r;
    logic                     ck_d_r;
    csist_pkg::csist_ch_t     st_r;
    csist_pkg::csist_ch_t     st_nxt;
    logic [csist_pkg::DW-1:0] sh_r;
    logic [csist_pkg::DW-1:0] buf_r;
    logic [3:0]               cnt_r;
    logic                     has_r;
    logic                     so_r;
    logic                     bff_r;
    logic                     ovf_r;
    logic                     irq_r;
    logic                     run_r;
    logic                     busy_r;
    logic                     slvl_r;
    logic                     clvl_r;
    logic                     pin_r;

    // Edge finding on the synchronised master clock
    wire ck        = sck_s2_r ^ CKP[c];                 // [R6]
    wire ck_rise   = ck & ~ck_d_r;
    wire ck_fall   = ~ck & ck_d_r;
    wire smp_edge  = DAP[c] ? ck_fall : ck_rise;        // [R5]
    wire sft_edge  = DAP[c] ? ck_rise : ck_fall;        // [R5]
    wire act       = (st_r == csist_pkg::CH_SHIFT);
    wire [3:0] len = LEN8[c] ? csist_pkg::LEN8_BITS : csist_pkg::LEN7_BITS; // [R18]

    // Sequencing terms
    wire run_nxt   = ~stop_ch[c] & (run_r | start_ch[c]); // [R7] [R9]
    wire take      = act & smp_edge & has_r;             // [R1]
    wire fend      = take & (cnt_r == len - csist_pkg::CNT_STEP);
    wire load      = run_r & run_nxt & bff_r & (~act | fend);
    wire shift_out = act & sft_edge & ~has_r;            // [R1]
    wire ovr       = run_r & smp_edge & ~act;            // [R3]
    wire lvl_ok    = LVL_WR[c] & ~run_r & ~CH_SOE[c];    // [R12]

    // Frame word in shift order, first bit at bit 0
    wire [csist_pkg::DW-1:0] rv   = csist_rev(buf_r);
    wire [csist_pkg::DW-1:0] word = ~MSB_FIRST[c] ? buf_r :
                                    (LEN8[c] ? rv : (rv >> 1)); // [R18]

    // Channel state next value
    assign st_nxt = ~run_nxt ? csist_pkg::CH_IDLE :
                    load     ? csist_pkg::CH_SHIFT :
                    fend     ? csist_pkg::CH_IDLE : st_r; // [R9]

    // Two-stage synchroniser and edge history
    always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
        sck_s1_r <= csist_pkg::CK_IDLE;
        sck_s2_r <= csist_pkg::CK_IDLE;
        ck_d_r   <= csist_pkg::CK_IDLE;
      end else begin
        sck_s1_r <= LINK.sck[c];
        sck_s2_r <= sck_s1_r;
        ck_d_r   <= ck;                                  // [R4]
      end
    end

    // Control, buffer and flags; clock removal clears the unit
    always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
        run_r  <= 1'b0;
        st_r   <= csist_pkg::CH_IDLE;
        buf_r  <= '0;
        bff_r  <= 1'b0;
        irq_r  <= 1'b0;
        ovf_r  <= 1'b0;
        busy_r <= 1'b0;
        slvl_r <= 1'b1;
        clvl_r <= 1'b1;
        pin_r  <= 1'b1;
      end else if (!PER_CLK_EN) begin                    // [R13]
        run_r  <= 1'b0;
        st_r   <= csist_pkg::CH_IDLE;
        buf_r  <= '0;
        bff_r  <= 1'b0;
        irq_r  <= 1'b0;
        ovf_r  <= 1'b0;
        busy_r <= 1'b0;
        slvl_r <= 1'b1;
        clvl_r <= 1'b1;
        pin_r  <= 1'b1;
      end else begin
        run_r  <= run_nxt;
        st_r   <= st_nxt;
        buf_r  <= DATA_WR[c] ? DATA_IN : buf_r;          // [R15] [R19]
        bff_r  <= DATA_WR[c] | (bff_r & ~load);          // [R19]
        irq_r  <= (load & IRQ_SEL[c]) | (fend & ~IRQ_SEL[c]); // [R2] [R16] [R17]
        ovf_r  <= ovr | (ovf_r & ~OVF_CLR[c]);           // [R3]
        busy_r <= act | bff_r;                           // [R10]
        if (lvl_ok) begin
          slvl_r <= SO_LVL[c];                           // [R12]
          clvl_r <= CKO_LVL[c];
        end
        pin_r  <= CH_SOE[c] ? so_r : slvl_r;             // [R8] [R11]
      end
    end

    // Shifter: load, present a bit, count a sampled bit
    always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
        sh_r  <= '0;
        cnt_r <= '0;
        has_r <= 1'b0;
        so_r  <= 1'b1;
      end else if (!PER_CLK_EN) begin                    // [R13]
        sh_r  <= '0;
        cnt_r <= '0;
        has_r <= 1'b0;
        so_r  <= 1'b1;
      end else if (load) begin
        sh_r  <= DAP[c] ? (word >> 1) : word;            // [R5]
        so_r  <= DAP[c] ? word[0] : so_r;                // [R5]
        has_r <= DAP[c];
        cnt_r <= '0;
      end else if (!run_nxt) begin
        has_r <= 1'b0;
      end else if (shift_out) begin
        so_r  <= sh_r[0];                                // [R1]
        sh_r  <= sh_r >> 1;
        has_r <= 1'b1;
      end else if (take) begin
        has_r <= 1'b0;
        cnt_r <= cnt_r + csist_pkg::CNT_STEP;
      end
    end

    // Port drive from flops
    assign RUNNING[c]  = run_r;
    assign BUSY[c]     = busy_r;
    assign BUF_FULL[c] = bff_r;
    assign OVF[c]      = ovf_r;
    assign IRQ[c]      = irq_r;
    assign CKO[c]      = clvl_r;
    assign LINK.so[c]  = pin_r;
  end

endmodule : csist_dev
`default_nettype wire

// ---- src/csist_pkg.sv ----
// Shared constants and types for the slave transmitter serial channel and its master
package csist_pkg;
  localparam int NCH = 2;                          // Channels in the unit
  localparam int CHW = 1;                          // Channel select width
  localparam int SS_W = 16;                        // Start and stop register width
  localparam int DW = 8;                           // Data register low byte width
  localparam logic [3:0] LEN7_BITS = 4'h7;         // Short frame
  localparam logic [3:0] LEN8_BITS = 4'h8;         // Long frame
  localparam logic [3:0] CNT_STEP = 4'h1;          // Bit counter step
  localparam int SCK_MIN_DIV = 6;                  // Serial clock at most operation clock / 6
  localparam int HOST_HALF = 8;                    // Master half period in operation clocks
  localparam logic CK_IDLE = 1'b1;                 // Internal clock idle level
  // Channel shift state
  typedef enum logic [0:0] {
    CH_IDLE  = 1'b0,
    CH_SHIFT = 1'b1
  } csist_ch_t;
  // Master sequencer state
  typedef enum logic [0:0] {
    HS_IDLE = 1'b0,
    HS_RUN  = 1'b1
  } csist_hs_t;
endpackage : csist_pkg

// ---- src/csist_if.sv ----
// Two-wire link per channel, clock and data, between the serial master and the slave transmitter
`timescale 1ns/1ps
`default_nettype none
interface csist_if;
  logic [csist_pkg::NCH-1:0] sck;  // Serial clock per channel, master drives
  logic [csist_pkg::NCH-1:0] so;   // Serial data per channel, slave drives
  modport dev (input sck, output so);
  modport host (output sck, input so);
endinterface : csist_if
`default_nettype wire

// ---- src/csist_host.sv ----
// Serial master end: divides its clock into the link clock and samples data
`timescale 1ns/1ps
`default_nettype none
module csist_host #(
  parameter int HALF = csist_pkg::HOST_HALF
) (
  input  wire logic                          REF_CLK,
  input  wire logic                          RST_B,
  input  wire logic                          GO,
  input  wire logic [csist_pkg::CHW-1:0]     CH_SEL,
  input  wire logic                          LEN8,
  input  wire logic                          DAP,
  input  wire logic [csist_pkg::NCH-1:0]     CKP,
  output logic                               BUSY,
  output logic                               DONE,
  output logic      [csist_pkg::DW-1:0]      RX_DATA,
  csist_if.host                              LINK
);

  localparam logic [7:0] HALF_M1 = 8'(HALF - 1);

  csist_pkg::csist_hs_t      st_r;
  logic [7:0]                hc_r;
  logic [4:0]                ed_r;
  logic [2:0]                idx_r;
  logic                      ck_r;
  logic [csist_pkg::CHW-1:0] ch_r;
  logic                      len8_r;
  logic                      dap_r;
  logic                      done_r;
  logic [csist_pkg::DW-1:0]  rx_r;
  logic [csist_pkg::NCH-1:0] so_s1_r;
  logic [csist_pkg::NCH-1:0] so_s2_r;
  logic [csist_pkg::NCH-1:0] sck_r;

  // Divider tick, edge bookkeeping; the master alone makes the clock
  wire       run    = (st_r == csist_pkg::HS_RUN);
  wire       tick   = run & (hc_r == HALF_M1);          // [R1] [R4]
  wire [3:0] len    = len8_r ? csist_pkg::LEN8_BITS : csist_pkg::LEN7_BITS;
  wire [4:0] tot_m1 = {len, 1'b0} - 5'h01;
  wire       last   = tick & (ed_r == tot_m1);
  wire       ck_nxt = run ? (tick ? ~ck_r : ck_r) : csist_pkg::CK_IDLE;
  wire       smp    = tick & (ck_nxt == ~dap_r);        // [R5]

  // Sequencer
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_r   <= csist_pkg::HS_IDLE;
      hc_r   <= '0;
      ed_r   <= '0;
      idx_r  <= '0;
      ck_r   <= csist_pkg::CK_IDLE;
      ch_r   <= '0;
      len8_r <= 1'b0;
      dap_r  <= 1'b0;
      done_r <= 1'b0;
      rx_r   <= '0;
    end else begin
      done_r <= last;
      ck_r   <= ck_nxt;
      if (!run) begin
        if (GO) begin
          st_r   <= csist_pkg::HS_RUN;
          ch_r   <= CH_SEL;
          len8_r <= LEN8;
          dap_r  <= DAP;
          hc_r   <= '0;
          ed_r   <= '0;
          idx_r  <= '0;
        end
      end else begin
        hc_r <= tick ? '0 : hc_r + 8'h01;
        if (tick) begin
          ed_r <= ed_r + 5'h01;
        end
        if (smp) begin
          rx_r[idx_r] <= so_s2_r[ch_r];
          idx_r       <= idx_r + 3'h1;
        end
        if (last) begin
          st_r <= csist_pkg::HS_IDLE;
        end
      end
    end
  end

  // Data input synchroniser and clock pins
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      so_s1_r <= '1;
      so_s2_r <= '1;
      sck_r   <= '1;
    end else begin
      so_s1_r <= LINK.so;
      so_s2_r <= so_s1_r;
      for (int c = 0; c < csist_pkg::NCH; c++) begin
        sck_r[c] <= ((run && (ch_r == c[csist_pkg::CHW-1:0])) ? ck_nxt
                     : csist_pkg::CK_IDLE) ^ CKP[c]; // [R6]
      end
    end
  end

  assign BUSY     = run;
  assign DONE     = done_r;
  assign RX_DATA  = rx_r;
  assign LINK.sck = sck_r;

endmodule : csist_host
`default_nettype wire

// ---- bench/csist_assertions.sv ----
// Concurrent checks on channel 0 control, status and interrupt, and on unit clear of both channels
`timescale 1ns/1ps
`default_nettype none
module csist_assertions (
  input wire logic        REF_CLK,
  input wire logic        RST_B,
  input wire logic        PER_CLK_EN,
  input wire logic        SS_WR,
  input wire logic [15:0] SS_DATA,
  input wire logic        ST_WR,
  input wire logic [15:0] ST_DATA,
  input wire logic [1:0]  DATA_WR,
  input wire logic [1:0]  IRQ_SEL,
  input wire logic [1:0]  CH_SOE,
  input wire logic [1:0]  LVL_WR,
  input wire logic [1:0]  CKO_LVL,
  input wire logic [1:0]  RUNNING,
  input wire logic [1:0]  BUF_FULL,
  input wire logic [1:0]  OVF,
  input wire logic [1:0]  IRQ,
  input wire logic [1:0]  CKO
);
  default clocking @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_B);
  // Stop request for channel 0
  wire stop0 = ST_WR && ST_DATA[0];
  AST_START: assert property (SS_WR && SS_DATA[0] && !stop0 && PER_CLK_EN |=> RUNNING[0])
    else $error("start did not set running");
  AST_STOP: assert property (stop0 |=> !RUNNING[0])
    else $error("stop did not clear running");
  AST_BUF_SET: assert property (DATA_WR[0] && PER_CLK_EN && !ST_WR |=> BUF_FULL[0])
    else $error("data write did not set buffer full");
  AST_UNIT_RST: assert property (!PER_CLK_EN |=> RUNNING == 2'h0 && BUF_FULL == 2'h0)
    else $error("clock removal did not clear the unit");
  AST_IRQ_ONE: assert property (IRQ[0] |=> !IRQ[0])
    else $error("interrupt longer than one cycle");
  AST_IRQ_EMPTY: assert property ($fell(BUF_FULL[0]) && RUNNING[0] && $past(RUNNING[0])
    && $past(IRQ_SEL[0]) && $past(PER_CLK_EN) |-> IRQ[0])
    else $error("buffer empty interrupt missing");
  AST_OVF_RUN: assert property ($rose(OVF[0]) |-> $past(RUNNING[0]))
    else $error("overrun while stopped");
  AST_FORCE: assert property (LVL_WR[0] && !RUNNING[0] && !CH_SOE[0] && PER_CLK_EN
    |=> CKO[0] == $past(CKO_LVL[0]))
    else $error("forced clock level not taken");
  AST_FORCE_NO: assert property (LVL_WR[0] && RUNNING[0] && PER_CLK_EN |=> $stable(CKO[0]))
    else $error("forced level taken while running");
endmodule : csist_assertions
`default_nettype wire

// ---- bench/csist_tb.sv ----
// Bench joining the slave transmitter to the serial master
`timescale 1ns/1ps
`default_nettype none
module csist_tb;
  logic        clk = 1'b0, rst_b = 1'b0, per_en = 1'b1, ss_wr = 1'b0, st_wr = 1'b0, go = 1'b0;
  logic [15:0] ss_d = 16'h0, st_d = 16'h0;
  logic [1:0]  soe = 2'h0, ckp = 2'h0, dap = 2'h0, isel = 2'h0, len8 = 2'h0, msb = 2'h0;
  logic [1:0]  dwr = 2'h0, oclr = 2'h0, lwr = 2'h0, solv = 2'h3, cklv = 2'h3;
  logic [1:0]  run, busy, bff, ovf, irq, cko;
  logic [7:0]  din = 8'h0, rx;
  logic [0:0]  ch = 1'b0;
  logic        hbusy, hdone;
  int          fail_count = 0, total_checks = 0, irqs = 0, n = 0, cycles = 0;
  logic [7:0]  exq[$];
  csist_if lnk ();
  always #2.5 clk = ~clk;
  csist_dev i_csist_dev (.REF_CLK(clk), .RST_B(rst_b), .PER_CLK_EN(per_en), .SS_WR(ss_wr),
    .SS_DATA(ss_d), .ST_WR(st_wr), .ST_DATA(st_d), .CH_SOE(soe), .CKP(ckp), .DAP(dap),
    .IRQ_SEL(isel), .LEN8(len8), .MSB_FIRST(msb), .DATA_WR(dwr), .DATA_IN(din),
    .OVF_CLR(oclr), .LVL_WR(lwr), .SO_LVL(solv), .CKO_LVL(cklv), .RUNNING(run), .BUSY(busy),
    .BUF_FULL(bff), .OVF(ovf), .IRQ(irq), .CKO(cko), .LINK(lnk));
  csist_host i_csist_host (.REF_CLK(clk), .RST_B(rst_b), .GO(go), .CH_SEL(ch),
    .LEN8(len8[ch]), .DAP(dap[ch]), .CKP(ckp), .BUSY(hbusy), .DONE(hdone), .RX_DATA(rx),
    .LINK(lnk));
  csist_assertions i_csist_assertions (.REF_CLK(clk), .RST_B(rst_b), .PER_CLK_EN(per_en),
    .SS_WR(ss_wr), .SS_DATA(ss_d), .ST_WR(st_wr), .ST_DATA(st_d), .DATA_WR(dwr),
    .IRQ_SEL(isel), .CH_SOE(soe), .LVL_WR(lwr), .CKO_LVL(cklv), .RUNNING(run),
    .BUF_FULL(bff), .OVF(ovf), .IRQ(irq), .CKO(cko));
  // Interrupt pulse count and hang guard
  always @(posedge clk) begin
    irqs <= irqs + int'(irq[0] === 1'b1) + int'(irq[1] === 1'b1);
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fail_count++;
      complete_run();
    end
  end
  task automatic complete_run();
    if (fail_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask : cyc
  // Expected arrival order of a frame
  function automatic logic [7:0] model(input logic [7:0] d, input logic l8, input logic mf);
    logic [7:0] r;
    int len;
    len = l8 ? 8 : 7;
    r = 8'h0;
    for (int i = 0; i < len; i++) begin
      r[i] = mf ? d[len - 1 - i] : d[i];
    end
    return r;
  endfunction : model
  task automatic ctl(input logic st, input logic [15:0] v);
    ss_d = v;
    st_d = v;
    ss_wr = !st;
    st_wr = st;
    cyc(1);
    ss_wr = 1'b0;
    st_wr = 1'b0;
    cyc(1);
  endtask : ctl
  task automatic wr(input logic [0:0] c, input logic [7:0] d, input logic ovr);
    if (ovr) exq[exq.size() - 1] = d;
    else exq.push_back(d);
    din = d;
    dwr[c] = 1'b1;
    cyc(1);
    dwr = 2'h0;
    cyc(1);
  endtask : wr
  task automatic xfer(input logic cmp);
    go = 1'b1;
    cyc(1);
    go = 1'b0;
    chk("host_busy", 16'h1, 16'(hbusy));
    for (int k = 0; k < 4000 && hdone !== 1'b1; k++) cyc(1);
    cyc(1);
    chk("host_busy", 16'h0, 16'(hbusy));
    if (cmp) chk("rx", 16'(model(exq.pop_front(), len8[ch], msb[ch])),
      16'(rx & (len8[ch] ? 8'hFF : 8'h7F)));
  endtask : xfer
  task automatic frame(input logic [4:0] m);
    ch = m[0];
    ckp = {2{m[1]}};
    dap[ch] = m[2];
    len8[ch] = m[3];
    msb[ch] = m[4];
    isel[ch] = m[1] ^ m[3];
    soe[ch] = 1'b1;
    cyc(4);
    n = irqs;
    ctl(1'b0, 16'h1 << ch);
    chk("running", 16'h1, 16'(run[ch]));
    wr(ch, 8'($urandom()), 1'b0);
    chk("busy", 16'h1, 16'(busy[ch]));
    cyc(4);
    xfer(1'b1);
    cyc(8);
    chk("irq_count", 16'(n + 1), 16'(irqs));
    chk("busy", 16'h0, 16'(busy[ch]));
    ctl(1'b1, 16'h1 << ch);
    chk("running", 16'h0, 16'(run[ch]));
    soe = 2'h0;
  endtask : frame
  initial begin
    void'($urandom(32'h1679c7f2));
    cyc(8);
    rst_b = 1'b1;
    cyc(2);
    for (int i = 0; i < 32; i++) frame(5'(i));
    // Continuous run with overwrite and late interrupt change
    {ch, ckp, dap, len8, msb, isel, soe} = {1'b0, 2'h0, 2'h0, 2'h1, 2'h0, 2'h1, 2'h1};
    cyc(4);
    n = irqs;
    ctl(1'b0, 16'h0001);
    wr(1'b0, 8'($urandom()), 1'b0);
    cyc(4);
    wr(1'b0, 8'($urandom()), 1'b0);
    wr(1'b0, 8'($urandom()), 1'b1);
    chk("buf_full", 16'h1, 16'(bff[0]));
    xfer(1'b1);
    cyc(10);
    isel[0] = 1'b0;
    xfer(1'b1);
    cyc(8);
    chk("irq_count", 16'(n + 3), 16'(irqs));
    // Clocking with nothing loaded, then clear
    xfer(1'b0);
    cyc(8);
    chk("ovf", 16'h1, 16'(ovf[0]));
    oclr[0] = 1'b1;
    cyc(1);
    oclr = 2'h0;
    cyc(2);
    chk("ovf", 16'h0, 16'(ovf[0]));
    // Forced levels refused while running, taken once stopped
    cklv = 2'h0;
    lwr = 2'h3;
    cyc(1);
    lwr = 2'h0;
    cyc(2);
    chk("cko_run", 16'h1, 16'(cko[0]));
    ctl(1'b1, 16'h0001);
    soe = 2'h0;
    {cklv, solv} = 4'hA;
    lwr = 2'h3;
    cyc(1);
    lwr = 2'h0;
    cyc(4);
    chk("cko", 16'h2, 16'(cko));
    chk("so", 16'h2, 16'(lnk.so));
    // Clock removal clears a running, loaded unit
    ctl(1'b0, 16'h0003);
    wr(1'b0, 8'h5A, 1'b0);
    wr(1'b0, 8'hC3, 1'b0);
    exq.delete();
    per_en = 1'b0;
    cyc(1);
    per_en = 1'b1;
    cyc(1);
    chk("unit", 16'h0, 16'({run, bff, ovf}));
    // Full setup again after the unit reset, master idle
    frame(5'h1F);
    complete_run();
  end
endmodule : csist_tb
`default_nettype wire
